// ### design/adc_ctrl.sv
`timescale 1ns/1ps
`include "adc_regs.svh"
module adc_ctrl
   import adc_pkg::*;
#(
   parameter int INT_STEP_CYC = `ADC_INT_STEP_CYC
) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   // Serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // Analog front end
   input wire logic cmp_high,
   output logic [3:0] pos_sel,
   output logic [3:0] neg_sel,
   output logic neg_com,
   output logic track_en,
   output logic cap_to_neg,
   output logic [11:0] dac_trial,
   // Decoded control and status
   output logic [7:0] conversion_control_byte,
   output logic pwr_down_full,
   output logic pwr_down_fast,
   output logic conv_busy,
   output logic [11:0] result,
   output logic result_valid
);
   localparam int STEP_W = $clog2(INT_STEP_CYC + 1);
   localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(INT_STEP_CYC - 1);

   adc_state_e state;
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic sclk_d;
   logic [7:0] sreg;
   logic [3:0] bit_cnt;
   logic [3:0] step_cnt;
   logic [11:0] sar;
   logic [STEP_W-1:0] div_cnt;
   logic int_tick;
   logic [11:0] rd_shift;
   logic [3:0] rd_cnt;
   logic cs_n_s;
   logic sclk_s;
   logic din_s;
   logic cmp_s;
   logic sclk_rise;
   logic sclk_fall;
   logic ext_mode;
   logic step_pulse;
   logic dec_bit;
   logic [11:0] next_sar;
   logic hold_evt;
   logic track_evt;

   assign cs_n_s = pin_sync[3];
   assign sclk_s = pin_sync[2];
   assign din_s = pin_sync[1];
   assign cmp_s = pin_sync[0];
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   // A fall seen with chip select already high belongs to no frame, so it never captures
   assign track_evt = (state == ADC_ST_SHIFT) && !cs_n_s && sclk_fall && (bit_cnt == `ADC_TRACK_BIT);
   assign hold_evt = (state == ADC_ST_SHIFT) && !cs_n_s && sclk_fall && (bit_cnt == `ADC_LAST_BIT);
   assign ext_mode = (adc_mode_e'(conversion_control_byte[1:0]) == ADC_MODE_EXT_CLK);
   assign step_pulse = ext_mode ? (sclk_fall & ~cs_n_s) : int_tick;
   // Offset-binary comparator decision; the MSB flips for two's complement
   assign dec_bit = (step_cnt == `ADC_MSB_STEP && !conversion_control_byte[`ADC_BIT_POLARITY]) ? ~cmp_s : cmp_s;

   always_comb begin
      next_sar = sar;
      next_sar[step_cnt] = cmp_s;
   end

   // Pins are asynchronous to clk
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         // Idle pin levels: chip select high, serial clock low, so no false edge follows reset
         pin_meta <= 4'h8;
         pin_sync <= 4'h8;
         sclk_d <= 1'b0;
      end else begin
         pin_meta <= {cs_n, sclk, din, cmp_high};
         pin_sync <= pin_meta;
         sclk_d <= sclk_s;
      end
   end

   // Internal conversion clock enable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= '0;
         int_tick <= 1'b0;
      end else if (state == ADC_ST_CONV && !ext_mode) begin
         int_tick <= (div_cnt == STEP_LAST);
         div_cnt <= (div_cnt == STEP_LAST) ? '0 : div_cnt + STEP_W'(1);
      end else begin
         div_cnt <= '0;
         int_tick <= 1'b0;
      end
   end

   // Frame sequencing
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ADC_ST_IDLE;
         sreg <= 8'h00;
         bit_cnt <= 4'h0;
      end else begin
         unique case (state)
            ADC_ST_IDLE: begin
               if (!cs_n_s) begin
                  state <= ADC_ST_HUNT;
               end
            end
            ADC_ST_HUNT: begin
               if (cs_n_s) begin
                  state <= ADC_ST_IDLE;
               end else if (sclk_rise && din_s) begin
                  state <= ADC_ST_SHIFT;
                  sreg <= 8'h01;
                  bit_cnt <= 4'h1;
               end
            end
            ADC_ST_SHIFT: begin
               if (cs_n_s) begin
                  state <= ADC_ST_IDLE;
                  bit_cnt <= 4'h0;
               end else if (sclk_rise && bit_cnt != `ADC_LAST_BIT) begin
                  sreg <= {sreg[6:0], din_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (sclk_fall && bit_cnt == `ADC_LAST_BIT) begin
                  state <= ADC_ST_CONV;
                  bit_cnt <= 4'h0;
               end
            end
            ADC_ST_CONV: begin
               // Only a serial-clocked conversion depends on the frame staying open
               if (ext_mode && cs_n_s) begin
                  state <= ADC_ST_IDLE;
               end else if (step_pulse && step_cnt == 4'h0) begin
                  state <= cs_n_s ? ADC_ST_IDLE : ADC_ST_HUNT;
               end
            end
         endcase
      end
   end

   // Control byte capture and power-down flags
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conversion_control_byte <= `ADC_CTRL_RESET;
         pwr_down_full <= 1'b0;
         pwr_down_fast <= 1'b0;
      end else if (hold_evt) begin
         conversion_control_byte <= sreg;
         pwr_down_full <= 1'b0;
         pwr_down_fast <= 1'b0;
      end else if (state == ADC_ST_CONV && step_pulse && step_cnt == 4'h0) begin
         pwr_down_full <= (adc_mode_e'(conversion_control_byte[1:0]) == ADC_MODE_PD_FULL);
         pwr_down_fast <= (adc_mode_e'(conversion_control_byte[1:0]) == ADC_MODE_PD_FAST);
      end
   end

   // Track/hold and input multiplexer
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         track_en <= 1'b0;
         cap_to_neg <= 1'b0;
         pos_sel <= 4'h0;
         neg_sel <= 4'h0;
         neg_com <= 1'b0;
      end else if (track_evt) begin
         track_en <= 1'b1;
         // Positive node depends only on the select bits, shared by both input configs
         unique case (sreg[3:1])
            3'b001: pos_sel <= 4'h1;
            3'b101: pos_sel <= 4'h2;
            3'b010: pos_sel <= 4'h4;
            3'b110: pos_sel <= 4'h8;
            default: pos_sel <= 4'h0;
         endcase
      end else if (hold_evt) begin
         track_en <= 1'b0;
         cap_to_neg <= 1'b1;
         neg_com <= sreg[`ADC_BIT_INPUT_CFG];
         if (sreg[`ADC_BIT_INPUT_CFG]) begin
            neg_sel <= 4'h0;
         end else begin
            unique case (sreg[`ADC_BIT_SEL_HI:`ADC_BIT_SEL_LO])
               3'b001: neg_sel <= 4'h2;
               3'b010: neg_sel <= 4'h8;
               3'b101: neg_sel <= 4'h1;
               3'b110: neg_sel <= 4'h4;
               default: neg_sel <= 4'h0;
            endcase
         end
      end else if (state == ADC_ST_CONV && ((ext_mode && cs_n_s) || (step_pulse && step_cnt == 4'h0))) begin
         track_en <= 1'b1;
         cap_to_neg <= 1'b0;
      end else if (state == ADC_ST_SHIFT && cs_n_s) begin
         track_en <= 1'b0;
      end
   end

   // Successive approximation
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sar <= 12'h000;
         step_cnt <= 4'h0;
         dac_trial <= 12'h000;
         result <= 12'h000;
         result_valid <= 1'b0;
         conv_busy <= 1'b0;
      end else begin
         result_valid <= 1'b0;
         if (hold_evt) begin
            sar <= 12'h000;
            step_cnt <= `ADC_MSB_STEP;
            dac_trial <= 12'h800;
            conv_busy <= 1'b1;
         end else if (state == ADC_ST_CONV && ext_mode && cs_n_s) begin
            conv_busy <= 1'b0;
         end else if (state == ADC_ST_CONV && step_pulse) begin
            sar <= next_sar;
            if (step_cnt == 4'h0) begin
               conv_busy <= 1'b0;
               result_valid <= 1'b1;
               result <= conversion_control_byte[`ADC_BIT_POLARITY] ? next_sar : {~next_sar[11], next_sar[10:0]};
            end else begin
               step_cnt <= step_cnt - 4'h1;
               dac_trial <= next_sar | (12'h001 << (step_cnt - 4'h1));
            end
         end
      end
   end

   // Serial output: live decisions in serial clock mode, stored word otherwise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
         rd_shift <= 12'h000;
         rd_cnt <= 4'h0;
      end else begin
         dout_oe <= ~cs_n_s;
         if (cs_n_s) begin
            dout <= 1'b0;
         end else if (state == ADC_ST_CONV && ext_mode && sclk_fall) begin
            dout <= dec_bit;
            rd_cnt <= 4'h0;
         end else if (result_valid && !ext_mode) begin
            rd_shift <= result;
            rd_cnt <= 4'hC;
         end else if (sclk_fall && state != ADC_ST_CONV) begin
            dout <= (rd_cnt != 4'h0) ? rd_shift[11] : 1'b0;
            rd_shift <= {rd_shift[10:0], 1'b0};
            rd_cnt <= (rd_cnt != 4'h0) ? rd_cnt - 4'h1 : 4'h0;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   AST_START_MSB: assert property (state == ADC_ST_HUNT && !cs_n_s && sclk_rise && din_s |=>
      state == ADC_ST_SHIFT && bit_cnt == 4'h1 && sreg == 8'h01) else $error("start bit not taken");
   AST_ZERO_IGNORED: assert property (state == ADC_ST_HUNT && !cs_n_s && sclk_rise && !din_s |=>
      state == ADC_ST_HUNT) else $error("leading zero left hunt");
   AST_TRACK_FIFTH: assert property (state == ADC_ST_SHIFT && !cs_n_s && sclk_fall && bit_cnt == 4'h5 |=>
      track_en && !cap_to_neg) else $error("tracking not started after bit five");
   AST_HOLD_EIGHTH: assert property (state == ADC_ST_SHIFT && !cs_n_s && sclk_fall && bit_cnt == 4'h8 |->
      track_en ##1 (!track_en && cap_to_neg && state == ADC_ST_CONV)) else $error("hold not entered after bit eight");
   AST_SGL_COM: assert property (state == ADC_ST_CONV && cap_to_neg && conversion_control_byte[2] |->
      neg_com && neg_sel == 4'h0) else $error("single-ended negative node not on common");
   AST_DIFF_PAIR: assert property (state == ADC_ST_CONV && cap_to_neg && !conversion_control_byte[2]
      && conversion_control_byte[6:4] == 3'b001 |-> !neg_com && neg_sel == 4'h2 && pos_sel == 4'h1)
      else $error("differential pair wrong");
   AST_ABORT: assert property (state == ADC_ST_SHIFT && cs_n_s |=> state == ADC_ST_IDLE &&
      $stable(conversion_control_byte) && !conv_busy) else $error("partial byte not discarded");
   AST_RECONNECT: assert property ($fell(conv_busy) |-> track_en && !cap_to_neg)
      else $error("hold capacitor not reconnected");
   AST_TWELVE_STEPS: assert property ($rose(conv_busy) |-> step_cnt == 4'hB && dac_trial == 12'h800)
      else $error("conversion not starting at MSB");
   AST_BIPOLAR_FMT: assert property (result_valid && !conversion_control_byte[3] |->
      result[11] == ~sar[11] && result[10:0] == sar[10:0]) else $error("bipolar coding wrong");
   AST_ONE_PULSE: assert property (result_valid |=> !result_valid)
      else $error("result pulse longer than one cycle");
   AST_EXT_ABORT: assert property (state == ADC_ST_CONV && ext_mode && cs_n_s |=>
      state == ADC_ST_IDLE && !conv_busy && !result_valid && track_en && !cap_to_neg)
      else $error("serial conversion not aborted");
   AST_POS_SGL: assert property (track_evt && sreg[3:1] == 3'b101 |=> pos_sel == 4'h2)
      else $error("second input not selected");
   AST_PD_FLAGS: assert property (result_valid |->
      pwr_down_full == (conversion_control_byte[1:0] == 2'b00) &&
      pwr_down_fast == (conversion_control_byte[1:0] == 2'b01)) else $error("power-down flag wrong");

   COV_SGL_CONV: cover property (result_valid && conversion_control_byte[2]);
   COV_DIFF_CONV: cover property (result_valid && !conversion_control_byte[2]);
   COV_ABORT: cover property (state == ADC_ST_SHIFT && cs_n_s);
   COV_INT_MODE: cover property (result_valid && conversion_control_byte[1:0] == 2'b10);
   COV_EXT_ABORT: cover property (state == ADC_ST_CONV && ext_mode && cs_n_s);
endmodule : adc_ctrl

// ### design/adc_pkg.sv
package adc_pkg;
   typedef enum logic [1:0] {
      ADC_ST_IDLE = 2'b00,
      ADC_ST_HUNT = 2'b01,
      ADC_ST_SHIFT = 2'b10,
      ADC_ST_CONV = 2'b11
   } adc_state_e;

   typedef enum logic [1:0] {
      ADC_MODE_PD_FULL = 2'b00,
      ADC_MODE_PD_FAST = 2'b01,
      ADC_MODE_INT_CLK = 2'b10,
      ADC_MODE_EXT_CLK = 2'b11
   } adc_mode_e;
endpackage : adc_pkg

// ### design/adc_regs.svh
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// Control byte field positions
`define ADC_BIT_START 3'd7
`define ADC_BIT_SEL_HI 3'd6
`define ADC_BIT_SEL_LO 3'd4
`define ADC_BIT_POLARITY 3'd3
`define ADC_BIT_INPUT_CFG 3'd2
`define ADC_CTRL_RESET 8'h00

// Serial bit counts
`define ADC_TRACK_BIT 4'd5
`define ADC_LAST_BIT 4'd8
`define ADC_RES_BITS 12
`define ADC_MSB_STEP 4'hB

// Internal conversion clock period, and its count of system clocks
`define ADC_CLK_MHZ 250
`define ADC_INT_STEP_NS 400
`define ADC_INT_STEP_CYC ((`ADC_INT_STEP_NS * `ADC_CLK_MHZ) / 1000)
`endif

// ### verif/adc_control_byte_track_hold_tb_top.sv
`timescale 1ns/1ps
module adc_control_byte_track_hold_tb_top;
   import adc_pkg::*;
   // Short internal step keeps each internally clocked conversion under 100 clocks
   localparam int STEP_CYC = 8;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cs_n, sclk, din;
   logic cmp_high = 1'b0;
   logic dout, dout_oe, neg_com, track_en, cap_to_neg;
   logic pwr_down_full, pwr_down_fast, conv_busy, result_valid;
   logic [3:0] pos_sel, neg_sel;
   logic [11:0] dac_trial, result;
   logic [7:0] conversion_control_byte;
   logic [11:0] target = 12'h000;
   int err_total = 0;
   int cmp_count = 0;
   int pulse_cnt = 0;
   logic [7:0] ctl_tab [8] = '{8'h9F, 8'hD7, 8'hAF, 8'hE7, 8'h92, 8'hA1, 8'hD0, 8'hEB};
   logic [3:0] pos_tab [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h4, 4'h2, 4'h8};
   logic [3:0] neg_tab [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h8, 4'h1, 4'h4};
   logic [11:0] tgt_tab [8] = '{12'hFFF, 12'h000, 12'h800, 12'h7FF, 12'h123, 12'hABC, 12'h5A5, 12'h001};

   always #2 clk = ~clk;
   // Comparator of the analog side: input at or above the trial code
   always @(negedge clk) cmp_high <= (target >= dac_trial);
   // Counted away from the launching edge so the one-cycle pulse is seen settled
   always @(negedge clk) begin
      if (result_valid === 1'b1) begin
         pulse_cnt++;
      end
   end

   adc_host_model adc_host_model_inst (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din));
   adc_ctrl #(.INT_STEP_CYC(STEP_CYC)) adc_ctrl_inst (
      .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
      .dout_oe(dout_oe), .cmp_high(cmp_high), .pos_sel(pos_sel), .neg_sel(neg_sel),
      .neg_com(neg_com), .track_en(track_en), .cap_to_neg(cap_to_neg), .dac_trial(dac_trial),
      .conversion_control_byte(conversion_control_byte), .pwr_down_full(pwr_down_full),
      .pwr_down_fast(pwr_down_fast), .conv_busy(conv_busy), .result(result),
      .result_valid(result_valid));

   task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      logic [7:0] ctl;
      logic [11:0] got;
      logic [11:0] exp;
      int n;
      int p0;
      repeat (6) @(negedge clk);
      sys_rst = 1'b0;
      check(track_en, 1'b0, "reset track");
      check(conversion_control_byte, 8'h00, "reset byte");
      for (int i = 0; i < 8; i++) begin
         ctl = ctl_tab[i];
         target = tgt_tab[i];
         exp = ctl[3] ? target : (target ^ 12'h800);
         p0 = pulse_cnt;
         if (i == 4) begin
            adc_host_model_inst.frame_begin();
            for (int b = 7; b > 3; b--) adc_host_model_inst.clk_bit(ctl[b]);
            adc_host_model_inst.frame_end();
            check(conversion_control_byte, ctl_tab[3], "partial byte");
            check(conv_busy, 1'b0, "partial busy");
         end
         adc_host_model_inst.frame_begin();
         for (int z = 0; z < i % 3; z++) adc_host_model_inst.clk_bit(1'b0);
         for (int b = 7; b >= 0; b--) begin
            adc_host_model_inst.clk_bit(ctl[b]);
            if (b == 4 && i == 0) check(track_en, 1'b0, "track early");
            if (b inside {3, 2, 1}) check(track_en, 1'b1, "acquire");
         end
         check(track_en, 1'b0, "hold");
         check(cap_to_neg, 1'b1, "cap to neg");
         check(pos_sel, pos_tab[i], "pos node");
         check(neg_sel, neg_tab[i], "neg node");
         check(neg_com, ctl[2], "com return");
         check(conversion_control_byte, ctl, "ctrl byte");
         check(dout_oe, 1'b1, "drive on");
         n = 0;
         while (ctl[1:0] != 2'b11 && conv_busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
         end
         if (n == 2000) begin
            err_total++;
            $display("[ERR] %0t busy never fell", $time);
            break;
         end
         for (int k = 0; k < 12; k++) begin
            adc_host_model_inst.clk_bit(1'b0);
            got[11-k] = dout;
         end
         check(got, exp, "dout word");
         check(result, exp, "result");
         check(12'(pulse_cnt - p0), 12'h001, "one result");
         check(track_en, 1'b1, "retrack");
         check(cap_to_neg, 1'b0, "cap back");
         check(pwr_down_full, ctl[1:0] == 2'b00, "full pd");
         check(pwr_down_fast, ctl[1:0] == 2'b01, "fast pd");
         adc_host_model_inst.frame_end();
         check(dout_oe, 1'b0, "drive off");
      end
      // Serial-clocked conversion cut short by chip select going high
      if (n < 2000) begin
         ctl = ctl_tab[0];
         target = tgt_tab[0];
         p0 = pulse_cnt;
         adc_host_model_inst.frame_begin();
         for (int b = 7; b >= 0; b--) adc_host_model_inst.clk_bit(ctl[b]);
         for (int k = 0; k < 3; k++) adc_host_model_inst.clk_bit(1'b0);
         check(conv_busy, 1'b1, "ext busy");
         adc_host_model_inst.frame_end();
         check(conv_busy, 1'b0, "abort busy");
         check(track_en, 1'b1, "abort retrack");
         check(cap_to_neg, 1'b0, "abort cap");
         check(12'(pulse_cnt - p0), 12'h000, "abort no result");
         check(conversion_control_byte, ctl, "abort byte");
      end
      conclude();
   end
endmodule : adc_control_byte_track_hold_tb_top

// ### verif/adc_host_model.sv
`timescale 1ns/1ps
module adc_host_model (
   // System
   input wire logic clk,
   // Serial link
   output logic cs_n,
   output logic sclk,
   output logic din
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_clk
   task automatic frame_begin();
      @(negedge clk);
      cs_n = 1'b0;
      wait_clk(20);
   endtask : frame_begin
   // 160 ns cycle; din moves only while sclk is low so it holds across the rise
   task automatic clk_bit(input logic b);
      din = b;
      wait_clk(10);
      sclk = 1'b1;
      wait_clk(20);
      sclk = 1'b0;
      wait_clk(10);
   endtask : clk_bit
   // Data line flips to the opposite level after deselect so no stale level is held
   task automatic frame_end();
      cs_n = 1'b1;
      din = ~din;
      wait_clk(20);
   endtask : frame_end
endmodule : adc_host_model
